// file: rtl/sps_defines.svh
// named constants of the synchronous serial port (register map, fields, divider counts)
// assumes one 25 MHz core clock and an 8-bit register port with 2-bit address
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

// ====================================================================
// register indexes
`define SPS_ADDR_DATA      2'h0
`define SPS_ADDR_CTRL      2'h1
`define SPS_ADDR_STAT      2'h2
`define SPS_ADDR_AUX       2'h3

// ====================================================================
// control register fields
`define SPS_CTRL_WRITE_COLLISION_FLAG      7
`define SPS_CTRL_OVF       6
`define SPS_CTRL_EN        5
`define SPS_CTRL_CKP       4
`define SPS_CTRL_RESET     8'h00

// ====================================================================
// status register fields
`define SPS_STAT_SMP       7
`define SPS_STAT_CKE       6
`define SPS_STAT_BF        0
`define SPS_STAT_RESET     8'h00

// ====================================================================
// auxiliary register fields
`define SPS_AUX_SDO_IN     0
`define SPS_AUX_INT_EN     1
`define SPS_AUX_IRQ        7
`define SPS_AUX_RESET      8'h00

// ====================================================================
// mode codes and master half-period lengths less one, in core clocks
`define SPS_MODE_M4        4'h0
`define SPS_MODE_M16       4'h1
`define SPS_MODE_M64       4'h2
`define SPS_MODE_S_SEL     4'h4
`define SPS_MODE_S_FREE    4'h5
`define SPS_HALF_M4        5'h01
`define SPS_HALF_M16       5'h07
`define SPS_HALF_M64       5'h1f
`define SPS_LAST_PHASE     5'h0f
`define SPS_LAST_BIT       3'h7

`endif

// file: rtl/sps_pkg.sv
// types shared by the synchronous serial port
// assumes sps_defines.svh supplies the numeric constants
package sps_pkg;

    // master sequencer states, one-hot
    typedef enum logic [1:0] {
        SPS_M_IDLE = 2'b01,
        SPS_M_RUN  = 2'b10
    } sps_mstate_t;

endpackage : sps_pkg

// file: rtl/sps_serial_port.sv
// synchronous serial port in spi mode: master or slave, 8-bit, msb first
// assumes clk at 25 MHz, srst synchronous, register port with read data one cycle late
`timescale 1ns/100ps
`include "sps_defines.svh"

module sps_serial_port (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       core_sleep,
    output logic            wake_req,
    input  wire logic       sck_in,
    output logic            sck_out,
    output logic            sck_oe,
    input  wire logic       sdi,
    output logic            sdo_out,
    output logic            sdo_oe,
    input  wire logic       ss_n
);

    // ================================================================
    // registers
    logic [7:0]           buf_reg;
    logic [7:0]           ctrl_reg;
    logic [7:0]           stat_reg;
    logic [7:0]           aux_reg;
    logic [7:0]           rdata_reg;
    logic [7:0]           sr_reg;
    logic [2:0]           bitcnt_reg;
    logic [4:0]           div_reg;
    logic [4:0]           phase_reg;
    logic                 sdo_reg;
    logic                 sck_reg;
    logic                 sck_s1_reg;
    logic                 sck_s2_reg;
    logic                 sck_s3_reg;
    logic                 ss_s1_reg;
    logic                 ss_s2_reg;
    sps_pkg::sps_mstate_t mstate_reg;

    // ================================================================
    // decoded controls
    logic       en;
    logic       clock_idle_polarity;
    logic       cke;
    logic       input_sample_phase;
    logic [3:0] mode;
    logic       is_master;
    logic       is_slave;
    logic       slave_gate;
    logic       busy;
    logic [4:0] half_len;
    logic       tick;
    logic       m_cap;
    logic       m_out;
    logic       s_edge;
    logic       s_lead;
    logic       s_cap;
    logic       s_out;
    logic       cap;
    logic       outp;
    logic       done;
    logic       wr_data;
    logic       start;
    logic       collide;
    logic       overflow;
    logic       load_buf;

    assign en   = ctrl_reg[`SPS_CTRL_EN];
    assign clock_idle_polarity  = ctrl_reg[`SPS_CTRL_CKP];
    assign mode = ctrl_reg[3:0];
    assign cke  = stat_reg[`SPS_STAT_CKE];
    assign input_sample_phase  = stat_reg[`SPS_STAT_SMP];

    // mode field decode; reserved codes leave the port inert
    assign is_master = en && (mode == `SPS_MODE_M4 || mode == `SPS_MODE_M16 ||
                              mode == `SPS_MODE_M64);
    assign is_slave  = en && (mode == `SPS_MODE_S_SEL || mode == `SPS_MODE_S_FREE);
    // select input only matters in the select-controlled slave mode
    assign slave_gate = is_slave && (mode == `SPS_MODE_S_FREE || !ss_s2_reg);

    // divider length per master rate
    always_comb begin
        unique case (mode)
            `SPS_MODE_M16: half_len = `SPS_HALF_M16;
            `SPS_MODE_M64: half_len = `SPS_HALF_M64;
            default:       half_len = `SPS_HALF_M4;
        endcase
    end

    // ================================================================
    // master timing: 16 sck half periods, one spare tick for late sampling
    // sleep stops ticks so the transfer holds its place
    assign tick  = (mstate_reg == sps_pkg::SPS_M_RUN) && !core_sleep &&
                   (div_reg == half_len);
    // capture on the edge opposite to output; smp moves it one half period later
    assign m_cap = tick && ((phase_reg[0] ^ input_sample_phase) != cke) &&
                   (input_sample_phase ? (phase_reg != 5'h00) : (phase_reg <= `SPS_LAST_PHASE));
    assign m_out = tick && (phase_reg[0] == cke) && (phase_reg <= `SPS_LAST_PHASE);

    // ================================================================
    // slave edges from the synchronised external clock
    assign s_edge = slave_gate && (sck_s2_reg != sck_s3_reg);
    assign s_lead = (sck_s3_reg == clock_idle_polarity);
    assign s_cap  = s_edge && (s_lead == cke);
    assign s_out  = s_edge && (s_lead != cke);

    assign cap  = is_master ? m_cap : s_cap;
    assign outp = is_master ? m_out : s_out;
    assign done = cap && (bitcnt_reg == `SPS_LAST_BIT);

    // ================================================================
    // software side events
    assign busy     = (mstate_reg == sps_pkg::SPS_M_RUN) ||
                      (is_slave && bitcnt_reg != 3'h0);
    assign wr_data  = reg_wr && (reg_addr == `SPS_ADDR_DATA);
    assign collide  = wr_data && busy;
    assign start    = wr_data && !busy && is_master;
    assign overflow = done && is_slave && stat_reg[`SPS_STAT_BF];
    assign load_buf = done && !overflow;

    // ================================================================
    // synchronisers for external clock and select
    always_ff @(posedge clk) begin
        if (srst) begin
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_s3_reg <= 1'b0;
            ss_s1_reg  <= 1'b1;
            ss_s2_reg  <= 1'b1;
        end else begin
            sck_s1_reg <= sck_in;
            sck_s2_reg <= sck_s1_reg;
            sck_s3_reg <= sck_s2_reg;
            ss_s1_reg  <= ss_n;
            ss_s2_reg  <= ss_s1_reg;
        end
    end

    // ================================================================
    // master sequencer and divider
    always_ff @(posedge clk) begin
        if (srst || !is_master) begin
            mstate_reg <= sps_pkg::SPS_M_IDLE;
            div_reg    <= 5'h00;
            phase_reg  <= 5'h00;
        end else begin
            unique case (mstate_reg)
                sps_pkg::SPS_M_IDLE: begin
                    if (start) begin
                        mstate_reg <= sps_pkg::SPS_M_RUN;
                        div_reg    <= 5'h00;
                        phase_reg  <= 5'h00;
                    end
                end
                sps_pkg::SPS_M_RUN: begin
                    if (!core_sleep) begin
                        div_reg <= tick ? 5'h00 : div_reg + 5'h01;
                    end
                    if (tick) begin
                        phase_reg <= phase_reg + 5'h01;
                        if (phase_reg == `SPS_LAST_PHASE + {4'h0, input_sample_phase}) begin
                            mstate_reg <= sps_pkg::SPS_M_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // serial clock output, idles at the programmed polarity
    always_ff @(posedge clk) begin
        if (srst) begin
            sck_reg <= 1'b0;
        end else if (!is_master || mstate_reg == sps_pkg::SPS_M_IDLE) begin
            sck_reg <= clock_idle_polarity;
        end else if (tick && phase_reg <= `SPS_LAST_PHASE) begin
            sck_reg <= ~sck_reg;
        end
    end

    // ================================================================
    // shift register, output bit and bit counter
    // a capture and an output in one cycle take the next bit from below
    always_ff @(posedge clk) begin
        if (srst) begin
            sr_reg     <= 8'h00;
            sdo_reg    <= 1'b0;
            bitcnt_reg <= 3'h0;
        end else if (!en || (is_slave && !slave_gate)) begin
            bitcnt_reg <= 3'h0;
            if (wr_data && is_slave) begin
                sr_reg  <= reg_wdata;
                sdo_reg <= reg_wdata[7];
            end
        end else if (wr_data && !busy) begin
            sr_reg     <= reg_wdata;
            sdo_reg    <= reg_wdata[7];
            bitcnt_reg <= 3'h0;
        end else begin
            if (cap) begin
                sr_reg     <= {sr_reg[6:0], sdi};
                bitcnt_reg <= bitcnt_reg + 3'h1;
            end
            if (outp) begin
                sdo_reg <= cap ? sr_reg[6] : sr_reg[7];
            end
        end
    end

    // ================================================================
    // data buffer: software writes while not busy load it, completed bytes replace it unless they overflow
    always_ff @(posedge clk) begin
        if (srst) begin
            buf_reg <= 8'h00;
        end else if (load_buf) begin
            buf_reg <= {sr_reg[6:0], sdi};
        end else if (wr_data && !busy) begin
            buf_reg <= reg_wdata;
        end
    end

    // ================================================================
    // control register; hardware set beats a software clear
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_reg <= `SPS_CTRL_RESET;
        end else begin
            if (reg_wr && reg_addr == `SPS_ADDR_CTRL) begin
                ctrl_reg <= reg_wdata;
            end
            if (collide) begin
                ctrl_reg[`SPS_CTRL_WRITE_COLLISION_FLAG] <= 1'b1;
            end
            if (overflow) begin
                ctrl_reg[`SPS_CTRL_OVF] <= 1'b1;
            end
        end
    end

    // status register: sample phase and edge writable, full flag read only
    always_ff @(posedge clk) begin
        if (srst) begin
            stat_reg <= `SPS_STAT_RESET;
        end else begin
            if (reg_wr && reg_addr == `SPS_ADDR_STAT) begin
                stat_reg[`SPS_STAT_SMP] <= reg_wdata[`SPS_STAT_SMP];
                stat_reg[`SPS_STAT_CKE] <= reg_wdata[`SPS_STAT_CKE];
            end
            if (reg_rd && reg_addr == `SPS_ADDR_DATA) begin
                stat_reg[`SPS_STAT_BF] <= 1'b0;
            end
            if (load_buf) begin
                stat_reg[`SPS_STAT_BF] <= 1'b1;
            end
        end
    end

    // auxiliary register: output-as-input, interrupt enable, byte flag
    always_ff @(posedge clk) begin
        if (srst) begin
            aux_reg <= `SPS_AUX_RESET;
        end else begin
            if (reg_wr && reg_addr == `SPS_ADDR_AUX) begin
                aux_reg[`SPS_AUX_SDO_IN] <= reg_wdata[`SPS_AUX_SDO_IN];
                aux_reg[`SPS_AUX_INT_EN] <= reg_wdata[`SPS_AUX_INT_EN];
                aux_reg[`SPS_AUX_IRQ]    <= reg_wdata[`SPS_AUX_IRQ];
            end
            if (done) begin
                aux_reg[`SPS_AUX_IRQ] <= 1'b1;
            end
        end
    end

    // read data stands in the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (srst || !reg_rd) begin
            rdata_reg <= 8'h00;
        end else begin
            unique case (reg_addr)
                `SPS_ADDR_DATA: rdata_reg <= buf_reg;
                `SPS_ADDR_CTRL: rdata_reg <= ctrl_reg;
                `SPS_ADDR_STAT: rdata_reg <= stat_reg;
                `SPS_ADDR_AUX:  rdata_reg <= aux_reg;
            endcase
        end
    end

    // ================================================================
    // pins; raw select gates the driver so release needs no sync delay
    assign reg_rdata = rdata_reg;
    assign sck_out   = sck_reg;
    assign sck_oe    = is_master;
    assign sdo_out   = sdo_reg;
    assign sdo_oe    = !aux_reg[`SPS_AUX_SDO_IN] && (is_master ||
                       (is_slave && (mode == `SPS_MODE_S_FREE || !ss_n)));
    assign wake_req  = core_sleep && aux_reg[`SPS_AUX_IRQ] &&
                       aux_reg[`SPS_AUX_INT_EN];

    // ================================================================
    // checks
    a_sdo_release: assert property (@(posedge clk) disable iff (srst)
        (is_slave && mode == `SPS_MODE_S_SEL && ss_n) |-> !sdo_oe)
        else $error("output driven while deselected");
    a_sdo_input: assert property (@(posedge clk) disable iff (srst)
        aux_reg[`SPS_AUX_SDO_IN] |-> !sdo_oe)
        else $error("output driven while configured as input");
    a_sdo_select: assert property (@(posedge clk) disable iff (srst)
        (is_slave && mode == `SPS_MODE_S_SEL && !ss_n && !aux_reg[`SPS_AUX_SDO_IN])
        |-> sdo_oe)
        else $error("output not driven while selected");
    a_start_run: assert property (@(posedge clk) disable iff (srst)
        (start && is_master) ##1 is_master |-> mstate_reg == sps_pkg::SPS_M_RUN)
        else $error("master write did not start transfer");
    // a received byte may land in the same cycle as a refused write
    a_collide_flag: assert property (@(posedge clk) disable iff (srst)
        (collide && !load_buf) |=> ctrl_reg[`SPS_CTRL_WRITE_COLLISION_FLAG] && $stable(buf_reg))
        else $error("busy write not flagged or not ignored");
    a_bf_load: assert property (@(posedge clk) disable iff (srst)
        load_buf |=> stat_reg[`SPS_STAT_BF] && aux_reg[`SPS_AUX_IRQ])
        else $error("load did not set full and byte flags");
    a_bf_read_clear: assert property (@(posedge clk) disable iff (srst)
        (reg_rd && reg_addr == `SPS_ADDR_DATA && !load_buf)
        |=> !stat_reg[`SPS_STAT_BF])
        else $error("buffer read did not clear full flag");
    a_ovf_keep: assert property (@(posedge clk) disable iff (srst)
        overflow |=> ctrl_reg[`SPS_CTRL_OVF] && $stable(buf_reg))
        else $error("overflow byte not discarded");
    a_bitcnt_clear: assert property (@(posedge clk) disable iff (srst)
        !en |=> bitcnt_reg == 3'h0)
        else $error("bit counter not cleared on disable");
    a_deselect_clear: assert property (@(posedge clk) disable iff (srst)
        (is_slave && mode == `SPS_MODE_S_SEL && ss_s2_reg) |=> bitcnt_reg == 3'h0)
        else $error("bit counter not cleared on deselect");
    a_sleep_hold: assert property (@(posedge clk) disable iff (srst)
        (core_sleep && is_master) ##1 (core_sleep && is_master)
        |-> $stable(phase_reg) && $stable(sck_reg))
        else $error("master moved during sleep");
    a_first_bit: assert property (@(posedge clk) disable iff (srst)
        start |=> sdo_out == $past(reg_wdata[7]))
        else $error("first bit not presented");
    // the last tick of a byte returns to idle, so no further tick follows
    a_div4_rate: assert property (@(posedge clk) disable iff (srst)
        (tick && mode == `SPS_MODE_M4 && !core_sleep) ##1 !core_sleep
        |-> !tick ##1 (tick || core_sleep || !is_master ||
                       mstate_reg == sps_pkg::SPS_M_IDLE))
        else $error("divide-by-4 rate wrong");

endmodule : sps_serial_port

// file: verif/sps_spi_peer.sv
// far-side spi device: slave while the port masters, master while the port is a slave
// assumes the bench loads it between frames and keeps hp at 3 or more
`timescale 1ns/100ps
module sps_spi_peer (
    input  wire logic       clk,
    input  wire logic       idle_pol,
    input  wire logic       edge_sel,
    input  wire logic       master,
    input  wire logic [5:0] hp,
    input  wire logic [4:0] stop_at,
    input  wire logic [7:0] tx,
    input  wire logic       load,
    input  wire logic       start,
    input  wire logic       dev_sck,
    input  wire logic       dev_sdo,
    input  wire logic       dev_sdo_oe,
    output logic            sck_line,
    output logic            data_out,
    output logic            ss_n,
    output logic      [7:0] rx,
    output logic            busy
);
    logic       msck, sp, adv, sdo_last, sdo_w, edg, cap, outp;
    logic [5:0] div;
    logic [4:0] tcnt;
    logic [7:0] sr;

    initial {busy, ss_n, msck, sp, adv, sdo_last, div, tcnt} = 17'h08000;

    // ==========
    // frame: select low, then toggles of hp+1 clocks; clock stands still between frames
    // plain always: the initial block above also sets these variables
    always @(posedge clk) begin
        if (start && !busy) begin
            busy <= 1'b1;
            ss_n <= 1'b0;
            div  <= 6'h00;
            tcnt <= 5'h00;
            msck <= idle_pol;
        end else if (busy && div != hp) begin
            div <= div + 6'h01;
        end else if (busy && tcnt == stop_at) begin
            busy <= 1'b0; // deselect may fall mid-byte when stop_at is short
            ss_n <= 1'b1;
        end else if (busy) begin
            div  <= 6'h00;
            msck <= ~msck;
            tcnt <= tcnt + 5'h01;
        end
    end

    // ==========
    // shifting: capture on one edge, next bit out on the other
    assign sck_line = master ? msck : dev_sck;
    assign data_out = sr[7];
    // a released output shows the inverse of its last level, never a held value
    assign sdo_w = dev_sdo_oe ? dev_sdo : ~sdo_last;
    assign edg   = sck_line != sp;
    assign cap   = edge_sel ? (edg && sck_line != idle_pol) : (edg && sck_line == idle_pol);
    assign outp  = edg && !cap;
    always @(posedge clk) begin
        sp       <= sck_line;
        sdo_last <= sdo_w;
        if (load) begin
            sr  <= tx;
            adv <= 1'b0;
        end else if (cap) begin
            rx  <= {rx[6:0], sdo_w};
            adv <= 1'b1;
        end else if (outp && adv) begin
            sr  <= {sr[6:0], 1'b0};
            adv <= 1'b0;
        end
    end
endmodule : sps_spi_peer

// file: verif/tb_top.sv
// self-checking bench: register tasks, master and slave exchanges against the peer
// assumes the peer model on the link and a 25 MHz core clock
`timescale 1ns/100ps
module tb_top;
    logic       clk, srst, wr_s, rd_s, slp, wake, sck_out, sck_oe, sdo_out, sdo_oe;
    logic       sck_line, pdata, ss_n, idle_pol, edge_sel, master, pload, pstart, pbusy;
    logic       sdo_in, msmp;
    logic [1:0] addr;
    logic [4:0] stop_at;
    logic [5:0] hp;
    logic [7:0] wd, rdata, ptx, prx;
    int         failures, total_checks;

    sps_serial_port u_sps_serial_port (
        .clk(clk), .srst(srst), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr_s),
        .reg_rd(rd_s), .reg_rdata(rdata), .core_sleep(slp), .wake_req(wake),
        .sck_in(sck_line), .sck_out(sck_out), .sck_oe(sck_oe), .sdi(pdata),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ss_n(ss_n));
    sps_spi_peer u_sps_spi_peer (
        .clk(clk), .idle_pol(idle_pol), .edge_sel(edge_sel), .master(master), .hp(hp),
        .stop_at(stop_at), .tx(ptx), .load(pload), .start(pstart), .dev_sck(sck_out),
        .dev_sdo(sdo_out), .dev_sdo_oe(sdo_oe), .sck_line(sck_line), .data_out(pdata),
        .ss_n(ss_n), .rx(prx), .busy(pbusy));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ==========
    // register port and comparison tasks
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd   <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic prime(input logic [7:0] t);
        ptx   <= t;
        pload <= 1'b1;
        @(posedge clk);
        pload <= 1'b0;
        #1;
    endtask : prime

    task automatic wait_bf();
        logic [7:0] s;
        int         i;
        s = 8'h00;
        for (i = 0; i < 400 && s[0] !== 1'b1; i++) begin
            rd(2'h2, s);
        end
        chk("full flag", 8'h01, {7'h00, s[0]});
    endtask : wait_bf

    task automatic cfg(input logic [7:0] c, input logic [7:0] s);
        wr(2'h1, 8'h00);
        wr(2'h2, s);
        wr(2'h1, c);
    endtask : cfg

    // ==========
    // one master exchange: first bit, clock rate, received byte, peer byte only while the output drives, flags
    task automatic mx(input logic [3:0] m, input logic p, input logic e,
                      input logic [7:0] dt, input logic [7:0] pt);
        logic [7:0] d;
        int         n;
        idle_pol = p;
        edge_sel = e;
        cfg({3'b001, p, m}, {msmp, e, 6'h00});
        // clear the byte flag; also lets a polarity change settle before the peer loads
        wr(2'h3, {7'h00, sdo_in});
        prime(pt);
        chk("clock idle", {7'h00, p}, sck_out);
        wr(2'h0, dt);
        @(posedge clk);
        #1 chk("first bit", {6'h00, dt[7], p}, {sdo_out, sck_out});
        chk("output drive", {7'h00, ~sdo_in}, sdo_oe);
        n = 0;
        while (sck_out === p && n < 99) begin
            @(posedge clk);
            #1 n++;
        end
        n = 0;
        while (sck_out !== p && n < 99) begin
            @(posedge clk);
            #1 n++;
        end
        chk("half period", 8'd2 << (2 * m), n[7:0]);
        wait_bf();
        rd(2'h0, d);
        chk("rx byte", pt, d);
        rd(2'h2, d);
        chk("status after read", {msmp, e, 6'h00}, d);
        rd(2'h3, d);
        chk("byte done flag", 8'h01, {7'h00, d[7]});
        rd(2'h1, d);
        chk("no collision", 8'h00, {7'h00, d[7]});
        if (!sdo_in) chk("peer rx", dt, prx);
    endtask : mx

    // ==========
    // one slave frame made by the peer; short stop_at deselects mid-byte
    task automatic sx(input logic [3:0] m, input logic [7:0] dt, input logic [7:0] pt,
                      input logic [4:0] stp);
        int i;
        wr(2'h0, dt);
        stop_at = stp;
        prime(pt);
        chk("idle drive", {7'h00, m == 4'h5}, sdo_oe);
        chk("slave clock input", 8'h00, sck_oe);
        @(posedge clk);
        pstart <= 1'b1;
        @(posedge clk);
        pstart <= 1'b0;
        @(posedge clk);
        #1 chk("selected drive", 8'h01, sdo_oe);
        i = 0;
        while (pbusy && i < 400) begin
            @(posedge clk);
            #1 i++;
        end
        if (stp == 5'd16) begin
            wait_bf();
            chk("peer rx", dt, prx);
        end else begin
            chk("released", 8'h00, sdo_oe);
        end
    endtask : sx

    task automatic wrap_up();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        wrap_up();
    end

    // ==========
    // main sequence
    initial begin
        logic [7:0] d;
        int         i;
        {srst, wr_s, rd_s, slp, pload, pstart, master, idle_pol, edge_sel, sdo_in} = 10'h200;
        {addr, wd, ptx, stop_at, hp, msmp, failures, total_checks} = 0;
        stop_at = 5'd16;
        hp = 6'd5;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        for (i = 1; i < 4; i++) begin
            rd(i[1:0], d);
            chk("reset register", 8'h00, d);
        end
        chk("pins after reset", 8'h00, {sck_oe, sdo_oe});
        wr(2'h2, 8'hff);
        rd(2'h2, d);
        chk("status writable bits", 8'hc0, d);
        for (i = 0; i < 3; i++) mx(i[3:0], 1'b0, 1'b1, 8'ha5 ^ i[7:0], 8'h3c + i[7:0]);
        for (i = 0; i < 4; i++) begin
            msmp = i[1]; // late input sampling with both edge choices
            mx(4'h0, i[1], ~i[0], 8'h96, 8'h69);
        end
        prime(8'h5a);
        wr(2'h0, 8'h3c);
        wr(2'h0, 8'hff);
        wait_bf();
        rd(2'h1, d);
        chk("collision", 8'h01, {7'h00, d[7]});
        chk("first byte kept", 8'h3c, prx);
        rd(2'h0, d);
        sdo_in = 1'b1;
        wr(2'h3, 8'h01);
        mx(4'h0, 1'b0, 1'b1, 8'h5a, 8'hc6);
        sdo_in = 1'b0;
        wr(2'h3, 8'h00);
        cfg(8'h22, 8'h40);
        prime(8'h81);
        wr(2'h0, 8'h7e);
        repeat (70) @(posedge clk);
        slp <= 1'b1;
        @(posedge clk);
        #1 d[0] = sck_out;
        repeat (96) @(posedge clk);
        #1 chk("frozen clock", {7'h00, d[0]}, sck_out);
        slp <= 1'b0;
        wait_bf();
        rd(2'h0, d);
        chk("resumed rx", 8'h81, d);
        chk("resumed tx", 8'h7e, prx);
        wr(2'h0, 8'hf0);
        repeat (5) @(posedge clk);
        wr(2'h1, 8'h00);
        #1 chk("disabled clock", 8'h00, sck_oe);
        cfg(8'h20, 8'h40);
        wr(2'h0, 8'h0f);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        rd(2'h1, d);
        chk("reset mid transfer", 8'h00, {d[7:1], sck_oe});
        mx(4'h0, 1'b0, 1'b1, 8'h24, 8'h42);
        master = 1'b1;
        idle_pol = 1'b0;
        edge_sel = 1'b0;
        cfg(8'h25, 8'h00);
        sx(4'h5, 8'h11, 8'h22, 5'd16);
        rd(2'h0, d);
        chk("slave rx", 8'h22, d);
        hp = 6'd11;
        sx(4'h5, 8'h33, 8'h44, 5'd16);
        sx(4'h5, 8'h55, 8'h66, 5'd16);
        rd(2'h1, d);
        chk("overflow", 8'h01, {7'h00, d[6]});
        rd(2'h0, d);
        // the write of the third byte reloaded the buffer; the overflowing byte is lost
        chk("kept byte", 8'h55, d);
        hp = 6'd5;
        edge_sel = 1'b1;
        cfg(8'h24, 8'h40);
        sx(4'h4, 8'hc3, 8'h3c, 5'd6);
        rd(2'h2, d);
        chk("no byte on deselect", 8'h00, {7'h00, d[0]});
        sx(4'h4, 8'ha7, 8'h7a, 5'd16);
        rd(2'h0, d);
        chk("selected rx", 8'h7a, d);
        wr(2'h3, 8'h02);
        slp <= 1'b1;
        @(posedge clk);
        #1 chk("no wake", 8'h00, wake);
        sx(4'h4, 8'h18, 8'h81, 5'd16);
        chk("wake", 8'h01, wake);
        slp <= 1'b0;
        wrap_up();
    end
endmodule : tb_top
